// ### src/fsc_defs.vh
/*
 Constants for the flash status/flag/high-address bookkeeping block.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef FSC_DEFS_VH
`define FSC_DEFS_VH
// Command opcodes
`define FSC_OP_WREN 8'h06
`define FSC_OP_WRDI 8'h04
`define FSC_OP_STWR 8'h01
`define FSC_OP_HAWR 8'hC5
`define FSC_OP_EN4 8'hB7
`define FSC_OP_EX4 8'hE9
`define FSC_OP_SUSP 8'h75
`define FSC_OP_RESM 8'h7A
`define FSC_OP_RSTEN 8'h66
`define FSC_OP_RST 8'h99
`define FSC_OP_PAGEWR 8'h02
`define FSC_OP_SMALLW 8'h20
`define FSC_OP_BLOCKW 8'hD8
`define FSC_OP_CHIPW 8'hC7
`define FSC_OP_NVCFG 8'hB1
`define FSC_OP_VCFG 8'h81
// Operation kinds
`define FSC_K_NONE 3'h0
`define FSC_K_PROG 3'h1
`define FSC_K_SWIPE 3'h2
`define FSC_K_BWIPE 3'h3
`define FSC_K_CWIPE 3'h4
`define FSC_K_STWR 3'h5
`define FSC_K_CFGWR 3'h6
// Reset values
`define FSC_STATUS_RST 8'h00
`define FSC_FLAG_RST 8'h80
`define FSC_HIADDR_RST 8'h00
// Read check chunk codes (config byte 4 bits 7:6)
`define FSC_CRC_OFF 2'h3
`define FSC_CRC_16 2'h2
`define FSC_CRC_32 2'h1
// Wrap length codes (config byte 7 bits 1:0)
`define FSC_WRAP_64 2'h2
`define FSC_WRAP_32 2'h1
`define FSC_LEN_16 7'h10
`define FSC_LEN_32 7'h20
`define FSC_LEN_64 7'h40
// Number of 64 KB blocks in the array
`define FSC_BLK_TOP 10'h200
`endif

// ### src/fsc_sync.v
/*
 Two-flop synchroniser, parameterised width and reset value.
 Assumes inputs are asynchronous to clk_i.
*/
`timescale 1ns/10ps
module fsc_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input wire clk_i,
    input wire rst_i,
    input wire [WIDTH-1:0] d_i,
    output wire [WIDTH-1:0] q_o
);
    reg [WIDTH-1:0] s1_q;
    reg [WIDTH-1:0] s2_q;

    // First stage feeds only the second stage
    always @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
        end
    end
    assign q_o = s2_q;
endmodule

// ### src/fsc_crc_app.v
/*
 Read data nibble shifter with per-line parity check bytes.
 Assumes sclk_i/cs_n_i already synchronised; data from same clock.
*/
`timescale 1ns/10ps
`include "fsc_defs.vh"
module fsc_crc_app (
    input wire clk_i,
    input wire rst_i,
    input wire sclk_i,
    input wire cs_n_i,
    input wire phase_i,
    input wire dtr_i,
    input wire [1:0] crc_cfg_i,
    input wire wrap_act_i,
    input wire [1:0] wrap_cfg_i,
    input wire [7:0] rd_data_i,
    input wire rd_valid_i,
    output reg rd_ready_o,
    output reg [3:0] io_o,
    output reg io_oen_o,
    output reg crc_slot_o
);
    reg sclk_d_q;
    reg half_q;
    reg [3:0] lo_q;
    reg [6:0] cnt_q;
    reg [3:0] par_hi_q;
    reg [3:0] par_lo_q;
    reg [6:0] chunk;
    wire crc_en = dtr_i && (crc_cfg_i != `FSC_CRC_OFF);
    wire rise = sclk_i & ~sclk_d_q;
    wire fall = ~sclk_i & sclk_d_q;
    wire act = phase_i & ~cs_n_i;
    wire shift = act & (dtr_i ? (rise | fall) : fall);
    wire due = crc_en && (cnt_q == chunk);
    wire [7:0] nxt = rd_valid_i ? rd_data_i : 8'hFF;

    // Wrap length overrides chunk while wrapped read runs
    always @* begin
        chunk = `FSC_LEN_64;
        if (wrap_act_i) begin
            if (wrap_cfg_i == `FSC_WRAP_64) chunk = `FSC_LEN_64;
            else if (wrap_cfg_i == `FSC_WRAP_32) chunk = `FSC_LEN_32;
            else chunk = `FSC_LEN_16;
        end else if (crc_cfg_i == `FSC_CRC_16) begin
            chunk = `FSC_LEN_16;
        end else if (crc_cfg_i == `FSC_CRC_32) begin
            chunk = `FSC_LEN_32;
        end
    end

    // High nibble first; check byte inserted after a whole chunk
    always @(posedge clk_i) begin
        if (rst_i) begin
            sclk_d_q <= 1'b0;
            half_q <= 1'b0;
            lo_q <= 4'h0;
            cnt_q <= 7'h00;
            par_hi_q <= 4'h0;
            par_lo_q <= 4'h0;
            rd_ready_o <= 1'b0;
            io_o <= 4'h0;
            io_oen_o <= 1'b1;
            crc_slot_o <= 1'b0;
        end else begin
            sclk_d_q <= sclk_i;
            rd_ready_o <= 1'b0;
            io_oen_o <= ~act;
            if (!act) begin
                half_q <= 1'b0;
                cnt_q <= 7'h00;
                par_hi_q <= 4'h0;
                par_lo_q <= 4'h0;
                crc_slot_o <= 1'b0;
            end else if (shift && half_q) begin
                io_o <= lo_q;
                half_q <= 1'b0;
            end else if (shift && due) begin
                io_o <= par_hi_q;
                lo_q <= par_lo_q;
                par_hi_q <= 4'h0;
                par_lo_q <= 4'h0;
                cnt_q <= 7'h00;
                crc_slot_o <= 1'b1;
                half_q <= 1'b1;
            end else if (shift) begin
                io_o <= nxt[7:4];
                lo_q <= nxt[3:0];
                par_hi_q <= par_hi_q ^ nxt[7:4];
                par_lo_q <= par_lo_q ^ nxt[3:0];
                cnt_q <= cnt_q + 7'h01;
                rd_ready_o <= 1'b1;
                crc_slot_o <= 1'b0;
                half_q <= 1'b1;
            end
        end
    end
endmodule

// ### src/fsc_regs.v
/*
 Status, flag status and high address registers of a serial NOR
 flash, with command gating and the read data check appender.
 Assumes a command decoder on MCLK_I presents one-cycle command
 strobes and an array engine reports completion and ECC events.
*/
`timescale 1ns/10ps
`include "fsc_defs.vh"
//
// Contract
// - Read check only in double-edge reads
// - Chunk length 16, 32 or 64 bytes
// - Wrap length overrides chunk during wrapped read
// - Check byte is per-line XOR over chunk
// - Check bytes follow every chunk; host reads chunks
// - Busy bit high during write operations
// - Write-enable latch mirrored; zero rejects writes
// - Area guard bits refuse program/erase inside region
// - Chip erase only with nothing guarded
// - Lock bits and protect pin gate status writes
// - Flag bit 0 shows address mode
// - Guard violation flag on protected access
// - Suspend flags set by suspend, cleared by resume
// - Program fail flag on failure or violation
// - Erase fail flag on failure or violation
// - Ready flag shows write cycle in progress
// - Segment bit defaults zero, own write command
// - Segment bit selects lower or upper half
// - Continuous read crosses segment, random stays
// - Chip erase ignores segment, others confined
// - Four-byte mode ignores segment bit
// - Corrected flag cleared on new read
// - Corrected flag set on single-bit correction
module fsc_regs (
    input wire MCLK_I,
    input wire RST_I,
    input wire SCLK_I,
    input wire CS_N_I,
    input wire WP_N_I,
    input wire CMD_VALID_I,
    input wire [7:0] CMD_OP_I,
    input wire [31:0] CMD_ADDR_I,
    input wire [7:0] CMD_DATA_I,
    input wire CMD_IS_READ_I,
    input wire CMD_RAND_I,
    input wire CMD_OTP_LOCKED_I,
    input wire OP_DONE_I,
    input wire OP_FAIL_I,
    input wire ECC_SEC_I,
    input wire [7:0] NV_STATUS_I,
    input wire STATUS_LOCK_BIT1_I,
    input wire ADDR4_CFG_I,
    input wire DTR_MODE_I,
    input wire [1:0] CRC_CFG_I,
    input wire WRAP_ACTIVE_I,
    input wire [1:0] WRAP_CFG_I,
    input wire DATA_PHASE_I,
    input wire [7:0] RD_DATA_I,
    input wire RD_VALID_I,
    output reg [7:0] STATUS_O,
    output reg [7:0] FLAG_O,
    output reg [7:0] HIADDR_O,
    output reg CMD_REJECT_O,
    output reg OP_START_O,
    output reg [2:0] OP_KIND_O,
    output reg [31:0] OP_ADDR_O,
    output reg SEG_CONFINE_O,
    output reg OP_PAUSE_O,
    output reg OP_RESUME_O,
    output wire RD_READY_O,
    output wire [3:0] IO_O,
    output wire IO_OEN_O,
    output wire CRC_SLOT_O
);
    reg [2:0] kind_q;
    reg [5:0] stage_q;
    reg susp_q;
    reg arm_q;
    reg load_q;
    reg [2:0] new_kind;
    wire [2:0] pin_s;

    // Pins cross into MCLK_I; chip select idles high
    fsc_sync #(
        .WIDTH(3),
        .RST_VAL(3'h2)
    ) u_sync (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .d_i({SCLK_I, CS_N_I, WP_N_I}),
        .q_o(pin_s)
    );

    // Read data path with chunk check bytes; the host configures it
    fsc_crc_app u_crc (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .sclk_i(pin_s[2]),
        .cs_n_i(pin_s[1]),
        .phase_i(DATA_PHASE_I),
        .dtr_i(DTR_MODE_I),
        .crc_cfg_i(CRC_CFG_I),
        .wrap_act_i(WRAP_ACTIVE_I),
        .wrap_cfg_i(WRAP_CFG_I),
        .rd_data_i(RD_DATA_I),
        .rd_valid_i(RD_VALID_I),
        .rd_ready_o(RD_READY_O),
        .io_o(IO_O),
        .io_oen_o(IO_OEN_O),
        .crc_slot_o(CRC_SLOT_O)
    );

    // Guarded region from the five area guard bits, 64 KB blocks
    function guard_hit;
        input [4:0] g;
        input [8:0] blk;
        reg [9:0] span;
        begin
            span = 10'h001 << (g[3:0] - 4'h1);
            if (g[3:0] == 4'h0) guard_hit = 1'b0;
            else if (g[3:0] > 4'h9) guard_hit = 1'b1;
            else if (g[4]) guard_hit = {1'b0, blk} < span;
            else guard_hit = {1'b0, blk} >= (`FSC_BLK_TOP - span);
        end
    endfunction

    wire busy = STATUS_O[0];
    wire write_enable_latch = STATUS_O[1];
    wire lock0 = STATUS_O[7];
    wire [4:0] guard = STATUS_O[6:2];
    wire addr4 = FLAG_O[0];
    wire seg = HIADDR_O[0];
    wire wp_high = pin_s[0];

    // Command classes
    wire is_wren = CMD_OP_I == `FSC_OP_WREN;
    wire is_wrdi = CMD_OP_I == `FSC_OP_WRDI;
    wire is_stwr = CMD_OP_I == `FSC_OP_STWR;
    wire is_hawr = CMD_OP_I == `FSC_OP_HAWR;
    wire is_en4 = CMD_OP_I == `FSC_OP_EN4;
    wire is_ex4 = CMD_OP_I == `FSC_OP_EX4;
    wire is_susp = CMD_OP_I == `FSC_OP_SUSP;
    wire is_resm = CMD_OP_I == `FSC_OP_RESM;
    wire is_rsten = CMD_OP_I == `FSC_OP_RSTEN;
    wire is_rst = CMD_OP_I == `FSC_OP_RST;
    wire is_prog = CMD_OP_I == `FSC_OP_PAGEWR;
    wire is_swipe = CMD_OP_I == `FSC_OP_SMALLW;
    wire is_bwipe = CMD_OP_I == `FSC_OP_BLOCKW;
    wire is_cwipe = CMD_OP_I == `FSC_OP_CHIPW;
    wire is_cfg = (CMD_OP_I == `FSC_OP_NVCFG) || (CMD_OP_I == `FSC_OP_VCFG);
    wire is_read = CMD_IS_READ_I;

    // Three-byte addresses take the segment bit on top
    wire [24:0] eff_addr = addr4 ? CMD_ADDR_I[24:0] : {seg, CMD_ADDR_I[23:0]};

    // Kind of internal operation a command starts
    always @* begin
        new_kind = `FSC_K_NONE;
        if (is_prog) new_kind = `FSC_K_PROG;
        else if (is_swipe) new_kind = `FSC_K_SWIPE;
        else if (is_bwipe) new_kind = `FSC_K_BWIPE;
        else if (is_cwipe) new_kind = `FSC_K_CWIPE;
        else if (is_stwr) new_kind = `FSC_K_STWR;
        else if (is_cfg) new_kind = `FSC_K_CFGWR;
    end

    wire k_prog = new_kind == `FSC_K_PROG;
    wire k_part = is_swipe | is_bwipe;
    wire needs_wel = new_kind != `FSC_K_NONE;
    // Lock0 alone hands control to the pin; both set freezes it
    wire st_wr_ok = !lock0 || (!STATUS_LOCK_BIT1_I && wp_high);
    wire area_hit = guard_hit(guard, eff_addr[24:16]);
    wire part_hit = (k_prog | k_part) & (area_hit | CMD_OTP_LOCKED_I);
    wire chip_hit = is_cwipe & (guard[3:0] != 4'h0);
    wire violate = part_hit | chip_hit;

    // Gating: busy admits only suspend and reset sequence
    wire g_busy = busy && !(is_susp || is_rsten || is_rst);
    wire g_wel = needs_wel && !write_enable_latch;
    wire g_st = is_stwr && !st_wr_ok;
    wire take = CMD_VALID_I && !g_busy && !g_wel && !g_st;
    wire start = take && needs_wel && !violate;
    wire bad = take && violate;
    wire soft_rst = take && is_rst && arm_q;
    wire k_is_prog = kind_q == `FSC_K_PROG;
    wire k_is_wipe = (kind_q == `FSC_K_SWIPE) || (kind_q == `FSC_K_BWIPE)
        || (kind_q == `FSC_K_CWIPE);

    // Register bank and operation bookkeeping
    always @(posedge MCLK_I) begin
        if (RST_I) begin
            STATUS_O <= `FSC_STATUS_RST;
            FLAG_O <= `FSC_FLAG_RST;
            HIADDR_O <= `FSC_HIADDR_RST;
            CMD_REJECT_O <= 1'b0;
            OP_START_O <= 1'b0;
            OP_KIND_O <= `FSC_K_NONE;
            OP_ADDR_O <= 32'h00000000;
            SEG_CONFINE_O <= 1'b0;
            OP_PAUSE_O <= 1'b0;
            OP_RESUME_O <= 1'b0;
            kind_q <= `FSC_K_NONE;
            stage_q <= 6'h00;
            susp_q <= 1'b0;
            arm_q <= 1'b0;
            load_q <= 1'b1;
        end else begin
            CMD_REJECT_O <= CMD_VALID_I && (!take || violate);
            OP_START_O <= start;
            OP_PAUSE_O <= 1'b0;
            OP_RESUME_O <= 1'b0;
            // Stored bits and address mode load after reset
            if (load_q) begin
                STATUS_O[7:2] <= NV_STATUS_I[7:2];
                FLAG_O[0] <= ADDR4_CFG_I;
                load_q <= 1'b0;
            end
            if (CMD_VALID_I) begin
                arm_q <= take && is_rsten;
            end
            if (take && is_wren) begin
                STATUS_O[1] <= 1'b1;
            end
            if (take && is_wrdi) begin
                STATUS_O[1] <= 1'b0;
            end
            // Only its own command loads the segment bit; soft reset clears it
            if (take && is_hawr) begin
                HIADDR_O[0] <= CMD_DATA_I[0];
            end
            if (take && is_en4) begin
                FLAG_O[0] <= 1'b1;
            end
            if (take && is_ex4) begin
                FLAG_O[0] <= 1'b0;
            end
            // Refused program or erase flags the error
            if (bad) begin
                STATUS_O[1] <= 1'b0;
                FLAG_O[1] <= 1'b1;
                FLAG_O[4] <= FLAG_O[4] | k_prog;
                FLAG_O[5] <= FLAG_O[5] | k_part | is_cwipe;
            end
            if (start) begin
                STATUS_O[1] <= 1'b0;
                STATUS_O[0] <= 1'b1;
                FLAG_O[7] <= 1'b0;
                kind_q <= new_kind;
                stage_q <= CMD_DATA_I[7:2];
                OP_KIND_O <= new_kind;
                OP_ADDR_O <= is_cwipe ? 32'h00000000 : {7'h00, eff_addr};
                SEG_CONFINE_O <= !addr4 && !is_cwipe;
            end
            // Reads: random access stays in segment, continuous runs on
            if (take && is_read) begin
                OP_ADDR_O <= {7'h00, eff_addr};
                OP_KIND_O <= `FSC_K_NONE;
                SEG_CONFINE_O <= !addr4 && CMD_RAND_I;
            end
            // Suspend pauses program or erase and frees the busy state
            if (take && is_susp && busy && (k_is_prog || k_is_wipe)) begin
                FLAG_O[6] <= k_is_wipe;
                FLAG_O[2] <= k_is_prog;
                STATUS_O[0] <= 1'b0;
                FLAG_O[7] <= 1'b1;
                susp_q <= 1'b1;
                OP_PAUSE_O <= 1'b1;
            end
            if (take && is_resm && susp_q) begin
                FLAG_O[6] <= 1'b0;
                FLAG_O[2] <= 1'b0;
                FLAG_O[1] <= 1'b0;
                if (k_is_prog) FLAG_O[4] <= 1'b0;
                if (k_is_wipe) FLAG_O[5] <= 1'b0;
                STATUS_O[0] <= 1'b1;
                FLAG_O[7] <= 1'b0;
                susp_q <= 1'b0;
                OP_RESUME_O <= 1'b1;
            end
            // Soft reset also drops latch and segment
            if (soft_rst) begin
                FLAG_O[6] <= 1'b0;
                FLAG_O[2] <= 1'b0;
                FLAG_O[0] <= ADDR4_CFG_I;
                STATUS_O[1] <= 1'b0;
                STATUS_O[0] <= 1'b0;
                FLAG_O[7] <= 1'b1;
                HIADDR_O[0] <= 1'b0;
                HIADDR_O[7] <= 1'b0;
                susp_q <= 1'b0;
                kind_q <= `FSC_K_NONE;
            end
            // Completion; a failed program or erase sets its fail flag
            if (OP_DONE_I && busy) begin
                STATUS_O[0] <= 1'b0;
                FLAG_O[7] <= 1'b1;
                if (kind_q == `FSC_K_STWR) STATUS_O[7:2] <= stage_q;
                if (OP_FAIL_I && k_is_prog) FLAG_O[4] <= 1'b1;
                if (OP_FAIL_I && k_is_wipe) FLAG_O[5] <= 1'b1;
                kind_q <= `FSC_K_NONE;
            end
            // New read clears the corrected flag; a correction wins
            if (take && is_read) begin
                HIADDR_O[7] <= 1'b0;
            end
            if (ECC_SEC_I) begin
                HIADDR_O[7] <= 1'b1;
            end
            HIADDR_O[6:1] <= 6'h00;
            FLAG_O[3] <= 1'b0;
        end
    end
endmodule

// ### dv/fsc_regs_chk.sv
/* Port checker for fsc_regs: gating, flags, check slot.
   Assumes a bind to fsc_regs; sees its ports only. */
`timescale 1ns/10ps
module fsc_regs_chk (
    input wire MCLK_I,
    input wire RST_I,
    input wire CS_N_I,
    input wire CMD_VALID_I,
    input wire [7:0] CMD_OP_I,
    input wire [7:0] CMD_DATA_I,
    input wire CMD_IS_READ_I,
    input wire ECC_SEC_I,
    input wire DTR_MODE_I,
    input wire [7:0] STATUS_O,
    input wire [7:0] FLAG_O,
    input wire [7:0] HIADDR_O,
    input wire CMD_REJECT_O,
    input wire OP_START_O,
    input wire [2:0] OP_KIND_O,
    input wire IO_OEN_O,
    input wire CRC_SLOT_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    // Non-read command passing the busy gate
    wire idle_cmd = CMD_VALID_I && !CMD_IS_READ_I && !STATUS_O[0];
    property p_wel_rej;
        CMD_VALID_I && CMD_OP_I == 8'h02 && !STATUS_O[1] |=> CMD_REJECT_O && !OP_START_O;
    endproperty
    a_wel_rej: assert property (p_wel_rej) else $error("program taken with latch low");
    property p_busy;
        OP_START_O && OP_KIND_O == 3'h1 |-> STATUS_O[0];
    endproperty
    a_busy: assert property (p_busy) else $error("program start without busy");
    property p_ready;
        STATUS_O[0] != FLAG_O[7];
    endproperty
    a_ready: assert property (p_ready) else $error("ready flag disagrees with busy");
    property p_resv;
        FLAG_O[3] == 1'b0 && HIADDR_O[6:1] == 6'h00;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bit set");
    property p_seg;
        idle_cmd && CMD_OP_I == 8'hC5 |=> HIADDR_O[0] == $past(CMD_DATA_I[0]);
    endproperty
    a_seg: assert property (p_seg) else $error("segment bit not written");
    property p_mode4;
        idle_cmd && CMD_OP_I == 8'hB7 |=> FLAG_O[0];
    endproperty
    a_mode4: assert property (p_mode4) else $error("four-byte mode not shown");
    property p_sec_set;
        ECC_SEC_I && !CMD_VALID_I |=> HIADDR_O[7];
    endproperty
    a_sec_set: assert property (p_sec_set) else $error("correction not flagged");
    property p_sec_clr;
        CMD_VALID_I && CMD_IS_READ_I && !ECC_SEC_I && !STATUS_O[0] |=> !HIADDR_O[7];
    endproperty
    a_sec_clr: assert property (p_sec_clr) else $error("correction flag kept on read");
    property p_str;
        !DTR_MODE_I && $past(DTR_MODE_I, 4) == 1'b0 |-> !CRC_SLOT_O;
    endproperty
    a_str: assert property (p_str) else $error("check byte in single-edge read");
    property p_oen;
        CS_N_I [*4] |-> IO_OEN_O;
    endproperty
    a_oen: assert property (p_oen) else $error("data lines driven while deselected");
endmodule

bind fsc_regs fsc_regs_chk u_chk (.MCLK_I(MCLK_I), .RST_I(RST_I), .CS_N_I(CS_N_I),
    .CMD_VALID_I(CMD_VALID_I), .CMD_OP_I(CMD_OP_I), .CMD_DATA_I(CMD_DATA_I),
    .CMD_IS_READ_I(CMD_IS_READ_I), .ECC_SEC_I(ECC_SEC_I), .DTR_MODE_I(DTR_MODE_I),
    .STATUS_O(STATUS_O), .FLAG_O(FLAG_O), .HIADDR_O(HIADDR_O), .CMD_REJECT_O(CMD_REJECT_O),
    .OP_START_O(OP_START_O), .OP_KIND_O(OP_KIND_O), .IO_OEN_O(IO_OEN_O),
    .CRC_SLOT_O(CRC_SLOT_O));

// ### dv/fsc_host_model.sv
/* Serial host model clocking read nibbles out of the block.
   Assumes the bench sets read mode first. */
`timescale 1ns/10ps
module fsc_host_model (
    output reg sclk_o,
    output reg cs_n_o,
    output reg phase_o,
    input wire [3:0] io_i,
    input wire slot_i
);
    reg [3:0] nib [0:131];
    reg slt [0:131];
    integer k;
    // Link clock low and deselected between frames
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        phase_o = 1'b0;
    end
    // Clocks n nibbles, recording data and slot flag after each
    task frame(input integer n, input dtr);
        begin
            cs_n_o = 1'b0;
            phase_o = 1'b1;
            #100;
            for (k = 0; k < n; k = k + 1) begin
                // Single-edge: data moves on falling edges
                if (!dtr) begin
                    sclk_o = 1'b1;
                    #62.5;
                end
                sclk_o = ~sclk_o;
                #60;
                nib[k] = io_i;
                slt[k] = slot_i;
                #2.5;
            end
            sclk_o = 1'b0;
            phase_o = 1'b0;
            cs_n_o = 1'b1;
            #100;
        end
    endtask
endmodule

// ### dv/testbench.sv
/* Self-checking bench for fsc_regs and its host model.
   Assumes the checker binds itself. */
`timescale 1ns/10ps
module testbench;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg wp_n = 1'b1, vld = 1'b0, is_rd = 1'b0, done = 1'b0, fail = 1'b0, sec = 1'b0;
    reg dtr = 1'b0, wrap = 1'b0, rdv = 1'b1;
    reg [7:0] op = 8'h00, dat = 8'h00, idx = 8'h00;
    reg [31:0] addr = 32'h00000000;
    reg [1:0] crc_cfg = 2'h3, wrap_cfg = 2'h0;
    wire sclk, cs_n, phase, rd_rdy, oen, slot, rej, start, seg, pause, resume;
    wire [3:0] io;
    wire [7:0] st, fl, ha;
    wire [2:0] kind;
    wire [31:0] oaddr;
    // Byte source changes per byte taken
    wire [7:0] rd_data = 8'h3C ^ {idx[4:0], 3'h5} ^ idx;
    integer err_total = 0, n_tests = 0;
    fsc_regs i_dut (.MCLK_I(clk), .RST_I(rst), .SCLK_I(sclk), .CS_N_I(cs_n), .WP_N_I(wp_n),
        .CMD_VALID_I(vld), .CMD_OP_I(op), .CMD_ADDR_I(addr), .CMD_DATA_I(dat),
        .CMD_IS_READ_I(is_rd), .CMD_RAND_I(is_rd), .CMD_OTP_LOCKED_I(1'b0), .OP_DONE_I(done),
        .OP_FAIL_I(fail), .ECC_SEC_I(sec), .NV_STATUS_I(8'h00), .STATUS_LOCK_BIT1_I(1'b0),
        .ADDR4_CFG_I(1'b0), .DTR_MODE_I(dtr), .CRC_CFG_I(crc_cfg), .WRAP_ACTIVE_I(wrap),
        .WRAP_CFG_I(wrap_cfg), .DATA_PHASE_I(phase), .RD_DATA_I(rd_data), .RD_VALID_I(rdv),
        .STATUS_O(st), .FLAG_O(fl), .HIADDR_O(ha), .CMD_REJECT_O(rej), .OP_START_O(start),
        .OP_KIND_O(kind), .OP_ADDR_O(oaddr), .SEG_CONFINE_O(seg), .OP_PAUSE_O(pause),
        .OP_RESUME_O(resume), .RD_READY_O(rd_rdy), .IO_O(io), .IO_OEN_O(oen),
        .CRC_SLOT_O(slot));
    fsc_host_model i_host (.sclk_o(sclk), .cs_n_o(cs_n), .phase_o(phase), .io_i(io),
        .slot_i(slot));
    initial begin
        forever #4 clk = ~clk;
    end
    // Step the byte source on each take
    always @(posedge clk) begin
        if (rd_rdy === 1'b1) begin
            idx <= idx + 8'h01;
        end
    end
    task chk(input [8*6-1:0] name, input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("MISMATCH %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    // One command strobe; outputs are sampled just after the taking edge
    task cmd(input [7:0] o, input [31:0] a, input [7:0] d, input r);
        begin
            @(posedge clk) vld <= 1'b1;
            op <= o;
            addr <= a;
            dat <= d;
            is_rd <= r;
            @(posedge clk) vld <= 1'b0;
            #1;
        end
    endtask
    task op1(input [7:0] o);
        cmd(o, 32'h00000000, 8'h00, 1'b0);
    endtask
    task wr(input [7:0] o, input [31:0] a);
        begin
            op1(8'h06);
            cmd(o, a, 8'h00, 1'b0);
        end
    endtask
    task fin(input f);
        begin
            @(posedge clk) done <= 1'b1;
            fail <= f;
            @(posedge clk) done <= 1'b0;
            fail <= 1'b0;
            #1;
        end
    endtask
    task t_reset;
        begin
            chk("st", st, 8'h00);
            chk("fl", fl, 8'h80);
            chk("ha", ha, 8'h00);
        end
    endtask
    task t_prog;
        begin
            cmd(8'h02, 32'h00123456, 8'h00, 1'b0);
            chk("rej", rej, 1);
            wr(8'h02, 32'h00123456);
            chk("go", {start, kind, st[1:0], fl[7]}, 7'b1_001_010);
            chk("adr", oaddr, 32'h00123456);
            fin(1'b0);
            chk("idle", {fl[7], st[0]}, 2'b10);
        end
    endtask
    task t_guard;
        begin
            op1(8'h06);
            cmd(8'h01, 32'h00000000, 8'h44, 1'b0);
            fin(1'b0);
            chk("grd", st[7:2], 6'h11);
            wr(8'h02, 32'h00000100);
            chk("pgm", {rej, fl[4], fl[1]}, 3'b111);
            wr(8'h20, 32'h00000000);
            chk("ers", {rej, fl[5]}, 2'b11);
            wr(8'hC7, 32'h00000000);
            chk("chip", rej, 1);
            wr(8'hD8, 32'h00800000);
            chk("out", start, 1);
            fin(1'b0);
        end
    endtask
    task t_lock;
        begin
            op1(8'h06);
            cmd(8'h01, 32'h00000000, 8'h80, 1'b0);
            fin(1'b0);
            chk("lck", st[7], 1);
            @(posedge clk) wp_n <= 1'b0;
            repeat (4) @(posedge clk);
            wr(8'h01, 32'h00000000);
            chk("wp0", rej, 1);
            @(posedge clk) wp_n <= 1'b1;
            repeat (4) @(posedge clk);
            wr(8'h01, 32'h00000000);
            chk("wp1", start, 1);
            fin(1'b0);
            chk("unl", st[7:2], 6'h00);
        end
    endtask
    task t_seg;
        begin
            cmd(8'hC5, 32'h00000000, 8'h01, 1'b0);
            chk("seg", ha, 8'h01);
            wr(8'h02, 32'h00001000);
            chk("hi", {seg, oaddr}, {1'b1, 32'h01001000});
            fin(1'b0);
            wr(8'hC7, 32'h00000000);
            chk("chip", {kind, seg}, 4'b100_0);
            fin(1'b0);
            op1(8'hB7);
            chk("4b", fl[0], 1);
            wr(8'h02, 32'h00002000);
            chk("4ba", oaddr, 32'h00002000);
            fin(1'b0);
            op1(8'hE9);
            cmd(8'hC5, 32'h00000000, 8'h00, 1'b0);
            chk("3b", {fl[0], ha[0]}, 2'b00);
        end
    endtask
    task t_susp;
        begin
            wr(8'h20, 32'h00010000);
            op1(8'h75);
            chk("sus", {pause, fl[6], fl[2], st[0]}, 4'b1100);
            op1(8'h7A);
            chk("res", {resume, fl[6], fl[5], fl[1], st[0]}, 5'b10001);
            fin(1'b1);
            chk("efl", fl[5], 1);
            wr(8'h02, 32'h00020000);
            op1(8'h75);
            chk("psus", fl[2], 1);
            op1(8'h66);
            op1(8'h99);
            chk("srst", {fl[6], fl[2]}, 2'b00);
        end
    endtask
    task t_ecc;
        begin
            @(posedge clk) sec <= 1'b1;
            @(posedge clk) sec <= 1'b0;
            #1;
            chk("sec", ha[7], 1);
            cmd(8'h03, 32'h00000000, 8'h00, 1'b1);
            chk("rd", {ha[7], seg}, 2'b01);
        end
    endtask
    task crc_run(input integer n, input integer at);
        integer i;
        reg [7:0] x;
        begin
            x = 8'h00;
            i_host.frame(n, 1'b1);
            for (i = 0; i < at; i = i + 2) begin
                x = x ^ {i_host.nib[i], i_host.nib[i+1]};
            end
            chk("slot", {i_host.slt[at-1], i_host.slt[at], i_host.slt[at+1]}, 3'b011);
            chk("crc", {i_host.nib[at], i_host.nib[at+1]}, x);
        end
    endtask
    task t_crc;
        integer i;
        reg any;
        begin
            @(posedge clk) dtr <= 1'b1;
            crc_cfg <= 2'h2;
            crc_run(34, 32);
            @(posedge clk) wrap <= 1'b1;
            wrap_cfg <= 2'h1;
            crc_run(66, 64);
            @(posedge clk) wrap <= 1'b0;
            crc_cfg <= 2'h0;
            crc_run(130, 128);
            @(posedge clk) dtr <= 1'b0;
            crc_cfg <= 2'h2;
            repeat (6) @(posedge clk);
            i_host.frame(34, 1'b0);
            any = 1'b0;
            for (i = 0; i < 34; i = i + 1) begin
                any = any | i_host.slt[i];
            end
            chk("str", any, 0);
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", n_tests, err_total);
            if (err_total == 0 && n_tests > 0) begin
                $display("TB: PASS");
            end else begin
                $display("TB: FAIL");
            end
            $finish;
        end
    endtask
    // Main sequence after a 16-cycle reset
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        t_reset;
        t_prog;
        t_guard;
        t_lock;
        t_seg;
        t_susp;
        t_ecc;
        t_crc;
        tally_and_finish;
    end
    // Watchdog well past the scenario time
    initial begin
        #300000;
        err_total = err_total + 1;
        tally_and_finish;
    end
endmodule
